// ---- hw/tac_activation.sv ----
`timescale 1ns/1ps
module tac_activation (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [17:2] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] ext_irq_i,
  input wire logic [39:0] src_req_i,
  input wire logic xfer_done_i,
  input wire logic xfer_interrupt_select_bit_i,
  input wire logic xfer_count_zero_i,
  input wire logic sw_interrupt_select_bit_clear_i,
  output logic xfer_start_o,
  output logic xfer_sw_o,
  output logic [5:0] xfer_src_o,
  output logic [6:0] xfer_vec_o,
  output logic irq_o
);

  typedef struct packed {
    logic [47:0] en;
    logic start;
    logic [6:0] vec;
    logic sw_req;
    logic sw_end;
    tac_pkg::tac_state_e st;
    logic cur_sw;
    logic [5:0] cur_src;
    logic go;
    logic ack;
    logic [31:0] rdat;
  } tac_main_s;

  tac_main_s s_q;
  tac_main_s s_d;

  logic [47:0] req_raw;
  logic [47:0] req_live;
  logic pick_any;
  logic [5:0] pick_idx;
  logic [1:0] ev;
  logic [1:0] irq_st;
  logic [1:0] irq_mask;
  logic bus_wr;
  logic [15:0] idx;
  logic [2:0] slot;
  logic st_wr;
  logic mask_wr;

  // External lines land in register A in reverse order, line 0 on bit 7.
  for (genvar g = 0; g < tac_pkg::N_EXT; g++) begin : g_ext
    assign req_raw[7 - g] = ext_irq_i[g];
  end
  assign req_raw[47:8] = src_req_i;

  // Positions without a source never raise a request, whatever software writes there.
  assign req_live = req_raw & s_q.en & tac_pkg::SRC_VALID;

  tac_prio_pick #(
    .N(tac_pkg::N_SRC),
    .W(tac_pkg::SRC_W)
  ) u_pick (
    .req_i(req_live),
    .any_o(pick_any),
    .idx_o(pick_idx)
  );

  // Writes take effect on the edge where the master sees ack, so a held request writes once.
  assign idx = wb_adr_i;
  assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & s_q.ack & wb_sel_i[0];
  assign st_wr = bus_wr & (idx == tac_pkg::IDX_IRQ_STAT);
  assign mask_wr = bus_wr & (idx == tac_pkg::IDX_IRQ_MASK);

  // Slot of the enable register that the current address names.
  always_comb begin
    unique case (idx)
      tac_pkg::IDX_EN_A: slot = 3'h0;
      tac_pkg::IDX_EN_B: slot = 3'h1;
      tac_pkg::IDX_EN_C: slot = 3'h2;
      tac_pkg::IDX_EN_D: slot = 3'h3;
      tac_pkg::IDX_EN_E: slot = 3'h4;
      tac_pkg::IDX_EN_I: slot = 3'h5;
      default: slot = tac_pkg::SLOT_NONE;
    endcase
  end

  // Next state: transfer completion first, then software writes, then a new launch.
  always_comb begin
    s_d = s_q;
    ev = tac_pkg::EV_RST;
    s_d.go = 1'b0;
    s_d.ack = wb_cyc_i & wb_stb_i & ~s_q.ack;

    // Completion decides whether the trigger survives.
    if ((s_q.st == tac_pkg::ST_BUSY) && xfer_done_i) begin
      if (s_q.cur_sw) begin
        if (!xfer_interrupt_select_bit_i && !xfer_count_zero_i) begin
          s_d.start = 1'b0;
        end else begin
          s_d.sw_end = 1'b1;
          ev[tac_pkg::EV_SW_END] = 1'b1;
        end
      end else if (xfer_interrupt_select_bit_i || xfer_count_zero_i) begin
        s_d.en[s_q.cur_src] = 1'b0;
        ev[tac_pkg::EV_HW_END] = 1'b1;
      end
      // Otherwise the enable bit is simply left alone.
    end

    // Software has dropped the select bit after the end interrupt.
    if (s_q.sw_end && sw_interrupt_select_bit_clear_i) begin
      s_d.start = 1'b0;
      s_d.sw_end = 1'b0;
    end

    // Software writes; a write of one to the start bit beats a hardware clear.
    if (bus_wr) begin
      if (slot != tac_pkg::SLOT_NONE) begin
        s_d.en[{slot, 3'h0} +: 8] = wb_dat_i[7:0];
      end else if (idx == tac_pkg::IDX_VEC) begin
        if (!s_q.start) begin
          s_d.vec = wb_dat_i[6:0];
        end
        if (wb_dat_i[tac_pkg::START_BIT]) begin
          if (!s_d.start) begin
            s_d.sw_req = 1'b1;
          end
          s_d.start = 1'b1;
        end
      end
    end

    // One transfer at a time; sources come before a software request.
    unique case (s_q.st)
      tac_pkg::ST_IDLE: begin
        if (pick_any) begin
          s_d.go = 1'b1;
          s_d.st = tac_pkg::ST_BUSY;
          s_d.cur_sw = 1'b0;
          s_d.cur_src = pick_idx;
        end else if (s_q.sw_req) begin
          s_d.go = 1'b1;
          s_d.st = tac_pkg::ST_BUSY;
          s_d.cur_sw = 1'b1;
          s_d.sw_req = 1'b0;
        end
      end
      tac_pkg::ST_BUSY: begin
        if (xfer_done_i) begin
          s_d.st = tac_pkg::ST_IDLE;
        end
      end
    endcase

    // Read data is captured with ack; unmapped words read as zero.
    if (s_d.ack) begin
      s_d.rdat = 32'h0;
      if (!wb_we_i) begin
        if (slot != tac_pkg::SLOT_NONE) begin
          s_d.rdat[7:0] = s_q.en[{slot, 3'h0} +: 8];
        end else if (idx == tac_pkg::IDX_VEC) begin
          s_d.rdat[7:0] = {s_q.start, s_q.vec};
        end else if (idx == tac_pkg::IDX_IRQ_STAT) begin
          s_d.rdat[1:0] = irq_st;
        end else if (idx == tac_pkg::IDX_IRQ_MASK) begin
          s_d.rdat[1:0] = irq_mask;
        end
      end
    end
  end

  // State register; reset leaves no source and no software request able to start.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.st <= tac_pkg::ST_IDLE;
      s_q.en <= tac_pkg::EN_RST;
      s_q.vec <= tac_pkg::VEC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  tac_irq_stat #(
    .N(tac_pkg::N_EV)
  ) u_irq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ev_i(ev),
    .st_wr_i(st_wr),
    .mask_wr_i(mask_wr),
    .wdat_i(wb_dat_i[1:0]),
    .st_o(irq_st),
    .mask_o(irq_mask),
    .irq_o(irq_o)
  );

  // The vector output is only meaningful with a software start; it is locked while start is set.
  assign wb_dat_o = s_q.rdat;
  assign wb_ack_o = s_q.ack;
  assign xfer_start_o = s_q.go;
  assign xfer_sw_o = s_q.cur_sw;
  assign xfer_src_o = s_q.cur_src;
  assign xfer_vec_o = s_q.vec;

  // Helper state that only the checks below read.
  logic [47:0] prev_en;
  logic vec_wr;
  logic en_wr;
  logic hw_done;
  logic sw_done;
  always_ff @(posedge clk_i) begin
    prev_en <= s_q.en;
  end
  assign vec_wr = bus_wr & (idx == tac_pkg::IDX_VEC);
  assign en_wr = bus_wr & (slot != tac_pkg::SLOT_NONE);
  assign hw_done = (s_q.st == tac_pkg::ST_BUSY) & xfer_done_i & ~s_q.cur_sw;
  assign sw_done = (s_q.st == tac_pkg::ST_BUSY) & xfer_done_i & s_q.cur_sw;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence seq_sw_keep;
    sw_done && (xfer_interrupt_select_bit_i || xfer_count_zero_i);
  endsequence

  sequence seq_sw_drop;
    sw_done && !xfer_interrupt_select_bit_i && !xfer_count_zero_i && !(vec_wr && wb_dat_i[7]);
  endsequence

  sequence seq_end_raised;
    s_q.start && s_q.sw_end ##1 irq_st[tac_pkg::EV_SW_END];
  endsequence

  chk_launch_enabled: assert property (
    xfer_start_o && !xfer_sw_o |-> prev_en[xfer_src_o] && tac_pkg::SRC_VALID[xfer_src_o])
    else $error("transfer started by a disabled source");

  chk_interrupt_select_bit_clears: assert property (
    hw_done && xfer_interrupt_select_bit_i && !en_wr |=> !s_q.en[$past(s_q.cur_src)])
    else $error("enable bit kept after a transfer with select set");

  chk_count_clears: assert property (
    hw_done && xfer_count_zero_i && !en_wr |=> !s_q.en[$past(s_q.cur_src)] && irq_st[tac_pkg::EV_HW_END])
    else $error("enable bit kept after the count ran out");

  chk_enable_holds: assert property (
    hw_done && !xfer_interrupt_select_bit_i && !xfer_count_zero_i && !en_wr |=> s_q.en == $past(s_q.en))
    else $error("enable bits changed although the transfer continues");

  chk_ext_order: assert property (
    s_q.st == tac_pkg::ST_IDLE && ext_irq_i[0] && s_q.en[7] && req_live[6:0] == 7'h00
    |=> xfer_start_o && xfer_src_o == 6'h07)
    else $error("external line 0 not mapped to enable bit 7");

  chk_start_by_one: assert property (
    $rose(s_q.start) |-> $past(vec_wr) && $past(wb_dat_i[7]))
    else $error("start bit set without a write of one");

  chk_vec_locked: assert property (
    vec_wr && s_q.start |=> s_q.vec == $past(s_q.vec))
    else $error("vector number changed while start bit set");

  chk_sw_vector: assert property (
    s_q.sw_req && s_q.st == tac_pkg::ST_IDLE && !pick_any |=> xfer_start_o && xfer_sw_o && xfer_vec_o == $past(s_q.vec))
    else $error("software start did not use the vector number");

  chk_interrupt_select_bit_release: assert property (
    seq_end_raised ##0 (sw_interrupt_select_bit_clear_i && !(vec_wr && wb_dat_i[7])) |=> !s_q.start && !s_q.sw_end)
    else $error("start bit not cleared after select dropped");

  chk_sw_drop: assert property (
    seq_sw_drop |=> !s_q.start)
    else $error("start bit kept after a continuing software transfer");

  chk_sw_keep: assert property (
    seq_sw_keep |=> s_q.start && s_q.sw_end ##1 irq_st[tac_pkg::EV_SW_END])
    else $error("software end interrupt missing");

  chk_reset_clear: assert property (
    $fell(rst_i) |-> s_q.en == '0 && s_q.vec == '0 && !s_q.start && !xfer_start_o)
    else $error("registers not clear after reset");

endmodule : tac_activation

// ---- hw/tac_irq_stat.sv ----
`timescale 1ns/1ps
module tac_irq_stat #(
  parameter int unsigned N = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [N-1:0] ev_i,
  input wire logic st_wr_i,
  input wire logic mask_wr_i,
  input wire logic [N-1:0] wdat_i,
  output logic [N-1:0] st_o,
  output logic [N-1:0] mask_o,
  output logic irq_o
);

  typedef struct packed {
    logic [N-1:0] st;
    logic [N-1:0] mask;
    logic irq;
  } tac_irq_s;

  tac_irq_s s_q;
  tac_irq_s s_d;

  // A one written to a status bit clears it, but an event in the same cycle wins.
  always_comb begin
    s_d = s_q;
    if (st_wr_i) begin
      s_d.st = s_q.st & ~wdat_i;
    end
    s_d.st = s_d.st | ev_i;
    if (mask_wr_i) begin
      s_d.mask = wdat_i;
    end
    s_d.irq = |(s_d.st & s_d.mask);
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign st_o = s_q.st;
  assign mask_o = s_q.mask;
  assign irq_o = s_q.irq;

  chk_event_sticks: assert property (@(posedge clk_i) disable iff (rst_i)
    (ev_i != '0) |=> ((st_o & $past(ev_i)) == $past(ev_i)))
    else $error("event did not set its status bit");

  chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 (irq_o == |(st_o & mask_o)))
    else $error("interrupt output disagrees with status and mask");

endmodule : tac_irq_stat

// ---- hw/tac_pkg.sv ----
package tac_pkg;

  // Word index of each register; the byte address on the bus is four times the index.
  localparam logic [15:0] IDX_EN_A = 16'hfe16;
  localparam logic [15:0] IDX_EN_B = 16'hfe17;
  localparam logic [15:0] IDX_EN_C = 16'hfe18;
  localparam logic [15:0] IDX_EN_D = 16'hfe19;
  localparam logic [15:0] IDX_EN_E = 16'hfe1a;
  localparam logic [15:0] IDX_EN_I = 16'hfe1e;
  localparam logic [15:0] IDX_VEC = 16'hfe1f;
  localparam logic [15:0] IDX_IRQ_STAT = 16'hfe20;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hfe21;

  // Geometry of the enable registers and of the source space.
  localparam int unsigned N_EN_REG = 6;
  localparam int unsigned N_SRC = 48;
  localparam int unsigned SRC_W = 6;
  localparam int unsigned N_EXT = 8;
  localparam int unsigned VEC_W = 7;
  localparam int unsigned START_BIT = 7;

  // Positions that have a source behind them, enable register A in the low byte.
  localparam logic [47:0] SRC_VALID = {8'hc0, 8'h0f, 8'h0f, 8'hc0, 8'h7f, 8'hff};

  // Slot number that marks an address outside the enable registers.
  localparam logic [2:0] SLOT_NONE = 3'h7;

  // Values after reset.
  localparam logic [47:0] EN_RST = 48'h0;
  localparam logic [6:0] VEC_RST = 7'h00;
  localparam logic [1:0] EV_RST = 2'h0;

  // Interrupt events of the status and mask registers.
  localparam int unsigned N_EV = 2;
  localparam int unsigned EV_HW_END = 0;
  localparam int unsigned EV_SW_END = 1;

  // Engine hand-off states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } tac_state_e;

endpackage : tac_pkg

// ---- hw/tac_prio_pick.sv ----
`timescale 1ns/1ps
module tac_prio_pick #(
  parameter int unsigned N = 48,
  parameter int unsigned W = 6
) (
  input wire logic [N-1:0] req_i,
  output logic any_o,
  output logic [W-1:0] idx_o
);

  // Lowest index wins; the loop walks downward so the last hit is the lowest one.
  always_comb begin
    any_o = 1'b0;
    idx_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        any_o = 1'b1;
        idx_o = W'(i);
      end
    end
  end

endmodule : tac_prio_pick

// ---- test/tac_activation_tb_top.sv ----
`timescale 1ns/1ps
module tac_activation_tb_top;
  logic clk_i, rst_i, cyc, stb, we, done, interrupt_select_bit, czero, swclr, interrupt_select_bit_cfg, czero_cfg;
  logic [15:0] adr;
  logic [31:0] wdat, rdat;
  logic [3:0] sel;
  logic [7:0] ext_irq, delay;
  logic ack, start, xsw, irq, last_sw;
  logic [5:0] src, last_src;
  logic [6:0] vec, last_vec;
  logic [39:0] src_req;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;
  int starts = 0;

  tac_activation dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_irq_i(ext_irq),
    .src_req_i(src_req), .xfer_done_i(done), .xfer_interrupt_select_bit_i(interrupt_select_bit), .xfer_count_zero_i(czero),
    .sw_interrupt_select_bit_clear_i(swclr), .xfer_start_o(start), .xfer_sw_o(xsw), .xfer_src_o(src), .xfer_vec_o(vec),
    .irq_o(irq));

  tac_engine_model eng_u (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .delay_i(delay),
    .interrupt_select_bit_cfg_i(interrupt_select_bit_cfg), .czero_cfg_i(czero_cfg), .done_o(done), .interrupt_select_bit_o(interrupt_select_bit), .czero_o(czero));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Record every launch; a hang is cut off well past the expected few hundred cycles.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (start === 1'b1) begin
      starts <= starts + 1;
      last_src <= src;
      last_sw <= xsw;
      last_vec <= vec;
    end
    if (cycles > 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  task stop_test;
    $display("Checks made %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One classic cycle, held until ack is sampled high at a rising edge.
  task wb(input logic [15:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    chk(ack, 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(a, 1'b1, d, q);
  endtask : wr

  task rd(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] q;
    wb(a, 1'b0, 8'h00, q);
    chk(q, exp);
  endtask : rd

  task wait_start(input int n0);
    for (int i = 0; i < 100 && starts == n0; i++) begin
      @(posedge clk_i);
    end
    chk(starts, n0 + 1);
  endtask : wait_start

  // Reset values, read-write access of every enable byte, and an unmapped address.
  task t_reset;
    logic [15:0] a;
    for (int i = 0; i < 6; i++) begin
      a = (i == 5) ? tac_pkg::IDX_EN_I : tac_pkg::IDX_EN_A + 16'(i);
      rd(a, 8'h00);
      wr(a, 8'hff);
      rd(a, 8'hff);
      wr(a, 8'h00);
    end
    rd(tac_pkg::IDX_VEC, 8'h00);
    wr(16'h0100, 8'h5a);
    rd(16'h0100, 8'h00);
    sel <= 4'h0;
    wr(tac_pkg::IDX_EN_A, 8'h5a);
    sel <= 4'h1;
    rd(tac_pkg::IDX_EN_A, 8'h00);
  endtask : t_reset

  // Hardware launches: hold, clear on select, clear on count, masking and clearing of the interrupt.
  task t_hw;
    int n;
    interrupt_select_bit_cfg <= 1'b0;
    czero_cfg <= 1'b0;
    delay <= 8'h02;
    n = starts;
    wr(tac_pkg::IDX_EN_A, 8'h80);
    ext_irq <= 8'h01;
    wait_start(n);
    chk(last_src, 6'h07);
    chk(last_sw, 1'b0);
    repeat (10) @(posedge clk_i);
    rd(tac_pkg::IDX_EN_A, 8'h80);
    interrupt_select_bit_cfg <= 1'b1;
    repeat (20) @(posedge clk_i);
    rd(tac_pkg::IDX_EN_A, 8'h00);
    rd(tac_pkg::IDX_IRQ_STAT, 8'h01);
    chk(irq, 1'b0);
    n = starts;
    repeat (20) @(posedge clk_i);
    chk(starts, n);
    wr(tac_pkg::IDX_IRQ_MASK, 8'h01);
    @(posedge clk_i);
    chk(irq, 1'b1);
    wr(tac_pkg::IDX_IRQ_STAT, 8'h01);
    @(posedge clk_i);
    chk(irq, 1'b0);
    interrupt_select_bit_cfg <= 1'b0;
    czero_cfg <= 1'b1;
    ext_irq <= 8'h80;
    n = starts;
    wr(tac_pkg::IDX_EN_A, 8'h01);
    wait_start(n);
    chk(last_src, 6'h00);
    repeat (10) @(posedge clk_i);
    rd(tac_pkg::IDX_EN_A, 8'h00);
    chk(starts, n + 1);
    ext_irq <= 8'h00;
    wr(tac_pkg::IDX_IRQ_STAT, 8'h01);
  endtask : t_hw

  // Other sources: a position with no source behind it never launches, a mapped one does.
  task t_src;
    int n;
    interrupt_select_bit_cfg <= 1'b0;
    czero_cfg <= 1'b1;
    delay <= 8'h02;
    src_req <= {40{1'b1}};
    n = starts;
    wr(tac_pkg::IDX_EN_B, 8'h80);
    repeat (20) @(posedge clk_i);
    chk(starts, n);
    wr(tac_pkg::IDX_EN_B, 8'h01);
    wait_start(n);
    chk(last_src, 6'h08);
    repeat (10) @(posedge clk_i);
    rd(tac_pkg::IDX_EN_B, 8'h00);
    chk(starts, n + 1);
    src_req <= 40'h0;
    wr(tac_pkg::IDX_IRQ_STAT, 8'h01);
  endtask : t_src

  // Software launches: write protection while pending, then both ways the start bit ends.
  task t_sw;
    int n;
    interrupt_select_bit_cfg <= 1'b0;
    czero_cfg <= 1'b0;
    delay <= 8'd40;
    n = starts;
    wr(tac_pkg::IDX_VEC, 8'h95);
    wait_start(n);
    chk(last_sw, 1'b1);
    chk(last_vec, 7'h15);
    wr(tac_pkg::IDX_VEC, 8'h00);
    rd(tac_pkg::IDX_VEC, 8'h95);
    wr(tac_pkg::IDX_VEC, 8'ha2);
    rd(tac_pkg::IDX_VEC, 8'h95);
    repeat (40) @(posedge clk_i);
    rd(tac_pkg::IDX_VEC, 8'h15);
    interrupt_select_bit_cfg <= 1'b1;
    n = starts;
    wr(tac_pkg::IDX_VEC, 8'h95);
    wait_start(n);
    repeat (50) @(posedge clk_i);
    rd(tac_pkg::IDX_VEC, 8'h95);
    rd(tac_pkg::IDX_IRQ_STAT, 8'h02);
    wr(tac_pkg::IDX_IRQ_MASK, 8'h02);
    rd(tac_pkg::IDX_IRQ_MASK, 8'h02);
    chk(irq, 1'b1);
    chk(starts, n + 1);
    swclr <= 1'b1;
    @(posedge clk_i);
    swclr <= 1'b0;
    @(posedge clk_i);
    rd(tac_pkg::IDX_VEC, 8'h15);
  endtask : t_sw

  // Main sequence after two cycles of reset.
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 16'h0;
    wdat = 32'h0;
    sel = 4'h1;
    ext_irq = 8'h00;
    src_req = 40'h0;
    swclr = 1'b0;
    interrupt_select_bit_cfg = 1'b0;
    czero_cfg = 1'b0;
    delay = 8'h02;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_hw();
    t_src();
    t_sw();
    stop_test();
  end
endmodule : tac_activation_tb_top

// ---- test/tac_engine_model.sv ----
`timescale 1ns/1ps
// Transfer engine stand-in: each launch is answered by one done pulse after a set delay.
module tac_engine_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [7:0] delay_i,
  input wire logic interrupt_select_bit_cfg_i,
  input wire logic czero_cfg_i,
  output logic done_o,
  output logic interrupt_select_bit_o,
  output logic czero_o
);
  logic [7:0] cnt_q;

  // Count down from the launch; a delay of one answers in the next cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 8'h00;
    end else if (start_i) begin
      cnt_q <= delay_i;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end

  // The qualifiers only mean something with done, so they wobble otherwise to expose early sampling.
  assign done_o = (cnt_q == 8'h01);
  assign interrupt_select_bit_o = done_o ? interrupt_select_bit_cfg_i : cnt_q[0];
  assign czero_o = done_o ? czero_cfg_i : ~cnt_q[0];
endmodule : tac_engine_model
